// ### design/pirf_flags.sv
// Purpose: Peripheral event flag register and reset cause status register.
// Assumes: Events are single-cycle pulses or levels synchronous to i_ref_clk.
// Notes:   Power-on and brown-out causes arrive as pulses from the reset logic.
`default_nettype none
module pirf_flags #(
   parameter bit FULL_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_reset,
   // Register port
   input  wire logic [pirf_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [pirf_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output var  logic [pirf_pkg::DATA_W-1:0]   o_rdata,
   // Peripheral events
   input  wire logic                          i_conv_done,
   input  wire logic                          i_conv_start,
   input  wire pirf_pkg::pirf_ccp_mode_t      i_ccp_mode,
   input  wire logic                          i_capture_event,
   input  wire logic                          i_compare_match,
   input  wire logic                          i_cmp1_out,
   input  wire logic                          i_cmp2_out,
   input  wire logic                          i_period_match,
   input  wire logic                          i_timer1_overflow,
   // Reset causes
   input  wire logic                          i_por_event,
   input  wire logic                          i_bor_event,
   // Status out
   output var  logic [pirf_pkg::DATA_W-1:0]   o_event_flags,
   output var  logic                          o_bor_enable
);
   import pirf_pkg::*;

   // The flag and status maps are byte wide, so any other width is refused.
   if (DATA_W != 8) begin : g_bad_width
      $error("pirf_flags: data width must be 8");
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIRF_SEL_NONE,
      PIRF_SEL_EVENT,
      PIRF_SEL_STATUS,
      PIRF_SEL_CTRL
   } pirf_sel_t;

   // Shared by the write decode and the read mux so that both follow one map.
   function automatic pirf_sel_t pirf_sel(input logic [ADDR_W-1:0] addr);
      pirf_sel_t sel;
      sel = PIRF_SEL_NONE;
      if (addr == OFF_EVENT_FLAGS) begin
         sel = PIRF_SEL_EVENT;
      end else if (addr == OFF_RESET_STATUS) begin
         sel = PIRF_SEL_STATUS;
      end else if (addr == OFF_BOR_CONTROL) begin
         sel = PIRF_SEL_CTRL;
      end
      return sel;
   endfunction : pirf_sel

   logic [7:0] impl_mask;
   logic       wr_event;
   logic       wr_status;
   logic       wr_ctrl;
   logic       cmp1_change;
   logic       cmp2_change;
   logic [7:0] hw_set;
   logic [7:0] event_flags;
   logic [7:0] next_event_flags;
   logic       por_ok;
   logic       bor_ok;
   logic       bor_en;
   logic [7:0] status_view;

   always_comb begin
      impl_mask = FULL_VARIANT ? EVENT_MASK_FULL : EVENT_MASK_REDUCED;
   end

   always_comb begin
      wr_event  = 1'b0;
      wr_status = 1'b0;
      wr_ctrl   = 1'b0;
      if (i_wr && pirf_sel(i_addr) == PIRF_SEL_EVENT) begin
         wr_event = 1'b1;
      end else if (i_wr && pirf_sel(i_addr) == PIRF_SEL_STATUS) begin
         wr_status = 1'b1;
      end else if (i_wr && pirf_sel(i_addr) == PIRF_SEL_CTRL) begin
         wr_ctrl = 1'b1;
      end
   end

   pirf_edge_det u_cmp1 (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_level   (i_cmp1_out),
      .o_change  (cmp1_change)
   );

   pirf_edge_det u_cmp2 (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_level   (i_cmp2_out),
      .o_change  (cmp2_change)
   );

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   // Enables live elsewhere; here only the capture/compare mode and the variant mask gate a set.
   always_comb begin
      hw_set                = 8'h00;
      hw_set[BIT_CONV_DONE] = i_conv_done;
      hw_set[BIT_CAPCMP]    = (i_ccp_mode == PIRF_CCP_CAPTURE && i_capture_event)
                           || (i_ccp_mode == PIRF_CCP_COMPARE && i_compare_match);
      hw_set[BIT_CMP2]      = cmp2_change;
      hw_set[BIT_CMP1]      = cmp1_change;
      hw_set[BIT_PERIOD]    = i_period_match;
      hw_set[BIT_OVF]       = i_timer1_overflow;
   end

   always_comb begin
      next_event_flags = event_flags;
      if (wr_event) begin
         next_event_flags = i_wdata;
      end
      // Starting a new conversion drops a stale done indication.
      if (i_conv_start) begin
         next_event_flags[BIT_CONV_DONE] = 1'b0;
      end
      next_event_flags = (next_event_flags | hw_set) & impl_mask;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         event_flags <= EVENT_RESET;
      end else begin
         event_flags <= next_event_flags;
      end
   end

   // ----------------------------------------------------------------
   // Reset cause status and brown-out control
   // ----------------------------------------------------------------
   // Reset value 0 marks the power-on that reset this logic.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         por_ok <= STATUS_RESET[BIT_POR];
      end else if (i_por_event) begin
         por_ok <= 1'b0;
      end else if (wr_status) begin
         por_ok <= i_wdata[BIT_POR];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         bor_ok <= STATUS_RESET[BIT_BOR];
      end else if (i_bor_event && bor_en) begin
         bor_ok <= 1'b0;
      end else if (wr_status) begin
         bor_ok <= i_wdata[BIT_BOR];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         bor_en <= BOR_EN_RESET;
      end else if (wr_ctrl) begin
         bor_en <= i_wdata[BIT_BOR_EN];
      end
   end

   always_comb begin
      status_view           = 8'h00;
      status_view[BIT_POR]  = por_ok;
      status_view[BIT_BOR]  = bor_ok && bor_en;
   end

   // ----------------------------------------------------------------
   // Read port and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         if (pirf_sel(i_addr) == PIRF_SEL_EVENT) begin
            o_rdata <= event_flags;
         end else if (pirf_sel(i_addr) == PIRF_SEL_STATUS) begin
            o_rdata <= status_view;
         end else if (pirf_sel(i_addr) == PIRF_SEL_CTRL) begin
            o_rdata <= {7'h00, bor_en};
         end else begin
            o_rdata <= 8'h00;
         end
      end else begin
         o_rdata <= 8'h00;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_event_flags <= EVENT_RESET;
         o_bor_enable  <= BOR_EN_RESET;
      end else begin
         o_event_flags <= next_event_flags;
         o_bor_enable  <= wr_ctrl ? i_wdata[BIT_BOR_EN] : bor_en;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_ovf_seen;
      i_timer1_overflow;
   endsequence

   sequence s_flag_held;
      event_flags[BIT_OVF] [*2];
   endsequence

   AST_OVF_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_ovf_seen |=> event_flags[BIT_OVF])
      else $error("overflow flag did not set");

   AST_OVF_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      event_flags[BIT_OVF] && !wr_event |=> event_flags[BIT_OVF])
      else $error("overflow flag dropped without a write");

   AST_OVF_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_ovf_seen ##1 (!wr_event) |-> s_flag_held)
      else $error("overflow flag not held");

   AST_SET_WINS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_event && (hw_set & impl_mask) != 8'h00
      |=> (event_flags & $past(hw_set & impl_mask)) == $past(hw_set & impl_mask))
      else $error("hardware set lost to a write");

   AST_CMP1: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmp1_change |=> event_flags[BIT_CMP1])
      else $error("first comparator flag missed");

   AST_CMP2: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      cmp2_change |=> event_flags[BIT_CMP2])
      else $error("second comparator flag missed");

   AST_PWM_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_ccp_mode == PIRF_CCP_PWM && !event_flags[BIT_CAPCMP]
      && !(wr_event && i_wdata[BIT_CAPCMP]) |=> !event_flags[BIT_CAPCMP])
      else $error("capture compare flag set in PWM mode");

   AST_UNIMPL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (event_flags & ~impl_mask) == 8'h00)
      else $error("unimplemented flag bit set");

   AST_BOR_OFF: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd && i_addr == OFF_RESET_STATUS && !bor_en |=> o_rdata[BIT_BOR] == 1'b0)
      else $error("brown-out bit visible while disabled");

   AST_POR_CLR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_por_event |=> !por_ok)
      else $error("power-on bit not cleared");

   AST_BOR_CLR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_bor_event && bor_en |=> !bor_ok)
      else $error("brown-out bit not cleared");

   AST_RD_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd && i_addr == OFF_RESET_STATUS |=> o_rdata[7:2] == 6'h00)
      else $error("status upper bits not zero");

   sequence s_conv_restart;
      i_conv_start && !i_conv_done && !wr_event;
   endsequence

   AST_CONV_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_conv_done |=> event_flags[BIT_CONV_DONE] == FULL_VARIANT)
      else $error("conversion done flag did not follow its event");

   AST_CONV_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      s_conv_restart |=> !event_flags[BIT_CONV_DONE])
      else $error("conversion done flag survived a new start");

   AST_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_ccp_mode == PIRF_CCP_CAPTURE && i_capture_event
      |=> event_flags[BIT_CAPCMP] == FULL_VARIANT)
      else $error("capture did not set its flag");

   AST_COMPARE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_ccp_mode == PIRF_CCP_COMPARE && i_compare_match
      |=> event_flags[BIT_CAPCMP] == FULL_VARIANT)
      else $error("compare match did not set its flag");

   AST_PERIOD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_period_match |=> event_flags[BIT_PERIOD] == FULL_VARIANT)
      else $error("period match flag missed");

   AST_ANY_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (hw_set & impl_mask) != 8'h00
      |=> (event_flags & $past(hw_set & impl_mask)) == $past(hw_set & impl_mask))
      else $error("event did not set its flag");

   AST_REDUCED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      !FULL_VARIANT |-> (o_event_flags & ~EVENT_MASK_REDUCED) == 8'h00)
      else $error("reduced variant shows a missing unit flag");

   AST_RD_EVENT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd && pirf_sel(i_addr) == PIRF_SEL_EVENT |=> !o_rdata[7] && !o_rdata[2])
      else $error("unimplemented flag bit read as one");

   AST_RD_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_rd && pirf_sel(i_addr) == PIRF_SEL_NONE |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");

   AST_POR_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_status && !i_por_event |=> por_ok == $past(i_wdata[BIT_POR]))
      else $error("power-on bit write lost");

   AST_BOR_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_status && !(i_bor_event && bor_en) |=> bor_ok == $past(i_wdata[BIT_BOR]))
      else $error("brown-out bit write lost");

   AST_EN_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      wr_ctrl |=> o_bor_enable == $past(i_wdata[BIT_BOR_EN]))
      else $error("brown-out enable write lost");

   AST_EN_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      !wr_ctrl |=> o_bor_enable == $past(o_bor_enable))
      else $error("brown-out enable changed without a write");

   AST_BOR_IGNORED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      i_bor_event && !bor_en && !wr_status |=> bor_ok == $past(bor_ok))
      else $error("brown-out event acted while disabled");
endmodule : pirf_flags
`default_nettype wire

// ### shared/pirf_pkg.sv
// Purpose: Constants for the peripheral event flag and reset cause status bank.
// Assumes: One 10 MHz core clock, plain register port with 8-bit data.
// Notes:   Register offsets are word indexes on the plain port.
`default_nettype none
package pirf_pkg;
   localparam int unsigned ADDR_W                 = 4;
   localparam int unsigned DATA_W                 = 8;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0]  OFF_EVENT_FLAGS        = 4'h0;
   localparam logic [3:0]  OFF_RESET_STATUS       = 4'h1;
   localparam logic [3:0]  OFF_BOR_CONTROL        = 4'h2;
   // ----------------------------------------------------------------
   // Event flag field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_CONV_DONE          = 6;
   localparam int unsigned BIT_CAPCMP             = 5;
   localparam int unsigned BIT_CMP2               = 4;
   localparam int unsigned BIT_CMP1               = 3;
   localparam int unsigned BIT_PERIOD             = 1;
   localparam int unsigned BIT_OVF                = 0;
   localparam logic [7:0]  EVENT_MASK_FULL        = 8'h7B;
   localparam logic [7:0]  EVENT_MASK_REDUCED     = 8'h19;
   // ----------------------------------------------------------------
   // Reset status and control fields
   // ----------------------------------------------------------------
   localparam int unsigned BIT_POR                = 1;
   localparam int unsigned BIT_BOR                = 0;
   localparam int unsigned BIT_BOR_EN             = 0;
   localparam logic [7:0]  EVENT_RESET            = 8'h00;
   localparam logic [1:0]  STATUS_RESET           = 2'b00;
   localparam logic        BOR_EN_RESET           = 1'b1;
   // ----------------------------------------------------------------
   // Capture/compare unit modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PIRF_CCP_OFF,
      PIRF_CCP_CAPTURE,
      PIRF_CCP_COMPARE,
      PIRF_CCP_PWM
   } pirf_ccp_mode_t;
endpackage : pirf_pkg
`default_nettype wire

// ### design/pirf_edge_det.sv
// Purpose: Change detector for one comparator output.
// Assumes: Input is synchronous to the core clock.
// Notes:   The first sample after reset is taken as the reference level.
`default_nettype none
module pirf_edge_det (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_reset,
   // Level in, change pulse out
   input  wire logic i_level,
   output var  logic o_change
);
   logic prev;
   logic primed;

   // Priming avoids a false change flag on the first cycle after reset.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         prev   <= 1'b0;
         primed <= 1'b0;
      end else begin
         prev   <= i_level;
         primed <= 1'b1;
      end
   end

   always_comb begin
      o_change = primed && (prev != i_level);
   end
endmodule : pirf_edge_det
`default_nettype wire

// ### bench/pirf_periph_model.sv
// Purpose: Event source model standing beside the flag bank.
// Assumes: The bench commands events as a mask at the rising edge.
// Notes:   Pulses leave one cycle after the command; bits 3 and 4 toggle comparators.
`default_nettype none
module pirf_periph_model (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // Command mask
   input  wire logic [7:0] i_fire,
   // Event lines
   output var  logic [7:0] o_pulse,
   output var  logic       o_cmp1,
   output var  logic       o_cmp2
);
   timeunit 1ns;
   timeprecision 1ns;
   // Comparator outputs are levels, so a command flips them rather than pulsing.
   always_ff @(posedge i_ref_clk) begin
      o_pulse <= i_reset ? 8'h00 : i_fire;
      o_cmp1  <= i_reset ? 1'b0 : o_cmp1 ^ i_fire[3];
      o_cmp2  <= i_reset ? 1'b0 : o_cmp2 ^ i_fire[4];
   end
endmodule : pirf_periph_model
`default_nettype wire

// ### bench/pirf_flags_tb_top.sv
// Purpose: Self-checking bench for the event flag and reset status bank.
// Assumes: The design carries its own assertions.
// Notes:   A reduced instance shares every input with the full one.
`default_nettype none
module pirf_flags_tb_top;
   import pirf_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic           clk   = 1'b0;
   logic           rst   = 1'b1;
   logic [3:0]     addr  = 4'h0;
   logic [7:0]     wdata = 8'h00;
   logic           wr    = 1'b0;
   logic           rd    = 1'b0;
   logic [7:0]     fire  = 8'h00;
   logic           por   = 1'b0;
   logic           bor   = 1'b0;
   pirf_ccp_mode_t mode  = PIRF_CCP_OFF;
   logic [7:0]     rdata, rrdata, flags, rflags, pulse, exp, m;
   logic           cmp1, cmp2, bor_en, rbor_en;
   int             fails       = 0;
   int             check_count = 0;
   initial forever #50 clk = ~clk;
   pirf_periph_model u_pirf_periph_model (.i_ref_clk(clk), .i_reset(rst), .i_fire(fire),
      .o_pulse(pulse), .o_cmp1(cmp1), .o_cmp2(cmp2));
   pirf_flags u_pirf_flags (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_conv_done(pulse[6]), .i_conv_start(pulse[2]),
      .i_ccp_mode(mode), .i_capture_event(pulse[5]), .i_compare_match(pulse[7]),
      .i_cmp1_out(cmp1), .i_cmp2_out(cmp2), .i_period_match(pulse[1]),
      .i_timer1_overflow(pulse[0]), .i_por_event(por), .i_bor_event(bor),
      .o_event_flags(flags), .o_bor_enable(bor_en));
   pirf_flags #(.FULL_VARIANT(1'b0)) u_pirf_flags_reduced (.i_ref_clk(clk), .i_reset(rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rrdata),
      .i_conv_done(pulse[6]), .i_conv_start(pulse[2]), .i_ccp_mode(mode),
      .i_capture_event(pulse[5]), .i_compare_match(pulse[7]), .i_cmp1_out(cmp1),
      .i_cmp2_out(cmp2), .i_period_match(pulse[1]), .i_timer1_overflow(pulse[0]),
      .i_por_event(por), .i_bor_event(bor), .o_event_flags(rflags), .o_bor_enable(rbor_en));
   // ----------------------------------------------------------------
   // Expectations and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] exp_set(input logic [7:0] c, input pirf_ccp_mode_t md);
      exp_set = {1'b0, c[6], (c[5] && md == PIRF_CCP_CAPTURE) || (c[7] && md == PIRF_CCP_COMPARE),
                 c[4], c[3], 1'b0, c[1], c[0]};
   endfunction : exp_set
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      check_count++;
      if (got !== want) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, got, want);
      end
   endtask : chk
   task automatic cf(input logic [7:0] want);
      chk(flags, want);
      chk(rflags, want & EVENT_MASK_REDUCED);
   endtask : cf
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] want);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      chk(rdata, want);
      chk(rrdata, (a == OFF_EVENT_FLAGS) ? (want & EVENT_MASK_REDUCED) : want);
   endtask : rd_reg
   task automatic ev(input logic [7:0] c, input pirf_ccp_mode_t md);
      @(posedge clk);
      fire <= c;
      mode <= md;
      @(posedge clk);
      fire <= 8'h00;
      repeat (3) @(posedge clk);
      #1;
   endtask : ev
   task automatic cause(input logic p, input logic b);
      @(posedge clk);
      por <= p;
      bor <= b;
      @(posedge clk);
      por <= 1'b0;
      bor <= 1'b0;
   endtask : cause
   task automatic close_out();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h1476a8cd));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cf(8'h00);
      rd_reg(OFF_RESET_STATUS, 8'h00);
      chk({6'h00, rbor_en, bor_en}, 8'h03);
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         if (k != 2) begin
            m = 8'h01 << k;
            ev(m, (k == 7) ? PIRF_CCP_COMPARE : PIRF_CCP_CAPTURE);
            cf(exp_set(m, mode));
            wr_reg(OFF_EVENT_FLAGS, 8'h00);
         end
      end
      ev(8'h20, PIRF_CCP_PWM);
      cf(8'h00);
      ev(8'h80, PIRF_CCP_CAPTURE);
      cf(8'h00);
      ev(8'h40, PIRF_CCP_OFF);
      cf(8'h40);
      ev(8'h04, PIRF_CCP_OFF);
      cf(8'h00);
      wr_reg(OFF_EVENT_FLAGS, 8'hFF);
      rd_reg(OFF_EVENT_FLAGS, EVENT_MASK_FULL);
      rd_reg(4'hF, 8'h00);
      wr_reg(OFF_EVENT_FLAGS, 8'h00);
      $display("test per-event done");
      // A write that clears must lose to an overflow landing on the same edge.
      @(posedge clk);
      fire <= 8'h01;
      @(posedge clk);
      fire  <= 8'h00;
      addr  <= OFF_EVENT_FLAGS;
      wdata <= 8'h00;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cf(8'h01);
      wr_reg(OFF_EVENT_FLAGS, 8'h00);
      $display("test collision done");
      wr_reg(OFF_RESET_STATUS, 8'hFF);
      rd_reg(OFF_RESET_STATUS, 8'h03);
      cause(1'b0, 1'b1);
      rd_reg(OFF_RESET_STATUS, 8'h02);
      cause(1'b1, 1'b0);
      rd_reg(OFF_RESET_STATUS, 8'h00);
      wr_reg(OFF_BOR_CONTROL, 8'h00);
      wr_reg(OFF_RESET_STATUS, 8'h03);
      rd_reg(OFF_RESET_STATUS, 8'h02);
      chk({6'h00, rbor_en, bor_en}, 8'h00);
      cause(1'b0, 1'b1);
      wr_reg(OFF_BOR_CONTROL, 8'h01);
      rd_reg(OFF_RESET_STATUS, 8'h03);
      wr_reg(OFF_RESET_STATUS, 8'h03);
      rd_reg(OFF_RESET_STATUS, 8'h03);
      $display("test status done");
      exp = 8'h00;
      for (int n = 0; n < 60; n++) begin
         m = 8'($urandom) & 8'hFB;
         ev(m, pirf_ccp_mode_t'($urandom_range(3, 0)));
         exp = exp | exp_set(m, mode);
         cf(exp);
         if (n % 8 == 7) begin
            wr_reg(OFF_EVENT_FLAGS, 8'h00);
            exp = 8'h00;
         end
      end
      $display("test random done");
      // A second reset must restore the power-on view after software changed it.
      wr_reg(OFF_BOR_CONTROL, 8'h00);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      cf(8'h00);
      chk({6'h00, rbor_en, bor_en}, 8'h03);
      rd_reg(OFF_RESET_STATUS, 8'h00);
      $display("test reset again done");
      close_out();
   end
   // The run needs well under 3000 cycles; a hang is cut at 6000.
   initial begin
      #(100 * 6000);
      fails++;
      close_out();
   end
endmodule : pirf_flags_tb_top
`default_nettype wire
